// ==== acsa_defs.svh ====
`ifndef ACSA_DEFS_SVH
`define ACSA_DEFS_SVH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ACSA_CTRL_ADDR 32'h4001c000
`define ACSA_SEQ_ADDR 32'h4001c008
`define ACSA_STAT_ADDR 32'h4001c0fc
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACSA_DIV_MSB 7
`define ACSA_ASYNC_BIT 8
`define ACSA_LP_BIT 10
`define ACSA_MASK_MSB 11
`define ACSA_TRIG_MSB 14
`define ACSA_TRIG_LSB 12
`define ACSA_POL_BIT 18
`define ACSA_SKIP_BIT 19
`define ACSA_START_BIT 26
`define ACSA_BURST_BIT 27
`define ACSA_SINGLE_BIT 28
`define ACSA_MODE_BIT 30
`define ACSA_EN_BIT 31
// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define ACSA_RESET_VALUE 32'h00000000
`define ACSA_CONV_TICKS 5'd31
`define ACSA_WARM_TICKS 5'd15
`define ACSA_NUM_CHANNELS 12
`endif

// ==== acsa_pkg.sv ====
package acsa_pkg;
  typedef enum logic [1:0] {ACSA_IDLE, ACSA_WARM, ACSA_LAUNCH, ACSA_CONV} acsa_state_type;

  typedef struct packed {
    logic [7:0] converter_clock_divider;
    logic async_sel;
    logic lp;
  } acsa_ctrl_type;

  typedef struct packed {
    logic [11:0] mask;
    logic [2:0] trig_sel;
    logic pol;
    logic skip;
    logic burst;
    logic single;
    logic mode;
    logic en;
  } acsa_seq_type;

  typedef struct packed {
    logic sample;
    logic done;
    logic seq_end;
    logic flag;
    logic adc_clk;
    logic [3:0] channel;
  } acsa_conv_type;

  typedef struct packed {
    acsa_ctrl_type ctrl;
    acsa_seq_type seq;
    acsa_state_type state;
    logic [7:0] div_cnt;
    logic [4:0] tick_cnt;
    logic [3:0] ch;
    logic sync1;
    logic sync2;
    logic prev;
    logic [31:0] rdata;
    acsa_conv_type conv;
  } acsa_regs_type;
endpackage

// ==== acsa_control.sv ====
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`include "acsa_defs.svh"

module acsa_control (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [7:0] trig_i,
  input wire logic async_tick_i,
  input wire logic analog_off_i,
  output acsa_pkg::acsa_conv_type conv_o,
  output logic analog_power_o,
  output logic busy_o
);
  acsa_pkg::acsa_regs_type r;
  acsa_pkg::acsa_regs_type next_r;
  logic trig_now;
  logic hw_edge;
  logic sw_start;
  logic trigger;
  logic tick;
  logic [4:0] nx;
  logic [4:0] first;
  logic [4:0] here;

  // ----------------------------------------
  // Next selected channel at or above a start
  // ----------------------------------------
  function automatic logic [4:0] find_ch(input logic [11:0] mask, input logic [4:0] from);
    logic [4:0] res;
    res = 5'h10;
    for (int i = `ACSA_NUM_CHANNELS - 1; i >= 0; i--) begin
      if (mask[i] && (5'(i) >= from)) begin
        res = 5'(i);
      end
    end
    return res;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_r = r;
    next_r.conv.sample = 1'b0;
    next_r.conv.done = 1'b0;
    next_r.conv.seq_end = 1'b0;
    next_r.conv.flag = 1'b0;
    next_r.conv.adc_clk = 1'b0;
    next_r.rdata = 32'h00000000;
    // Trigger path
    next_r.sync1 = trig_i[r.seq.trig_sel];
    next_r.sync2 = r.sync1;
    trig_now = r.seq.skip ? trig_i[r.seq.trig_sel] : r.sync2;
    next_r.prev = trig_now;
    hw_edge = r.seq.pol ? (trig_now & ~r.prev) : (~trig_now & r.prev);
    sw_start = wr_i && (addr_i == `ACSA_SEQ_ADDR) && wdata_i[`ACSA_START_BIT];
    trigger = r.seq.en && !r.seq.burst && (hw_edge || sw_start);
    // Converter clock
    if (r.ctrl.async_sel) begin
      tick = async_tick_i;
      next_r.div_cnt = 8'h00;
    end else begin
      tick = (r.div_cnt == r.ctrl.converter_clock_divider);
      if (r.state == acsa_pkg::ACSA_IDLE || r.state == acsa_pkg::ACSA_LAUNCH || tick) begin
        next_r.div_cnt = 8'h00;
      end else begin
        next_r.div_cnt = r.div_cnt + 8'h01;
      end
    end
    first = find_ch(r.seq.mask, 5'h00);
    here = find_ch(r.seq.mask, {1'b0, r.ch});
    nx = find_ch(r.seq.mask, {1'b0, r.ch} + 5'h01);
    if (r.state != acsa_pkg::ACSA_IDLE) begin
      next_r.conv.adc_clk = tick;
    end
    // Sequencer
    case (r.state)
      acsa_pkg::ACSA_IDLE: begin
        if ((trigger || (r.seq.en && r.seq.burst)) && r.seq.mask != 12'h000) begin
          if (here == 5'h10) begin
            next_r.ch = first[3:0];
          end else begin
            next_r.ch = here[3:0];
          end
          next_r.tick_cnt = 5'h00;
          next_r.state = r.ctrl.lp ? acsa_pkg::ACSA_WARM : acsa_pkg::ACSA_LAUNCH;
        end
      end
      acsa_pkg::ACSA_WARM: begin
        if (tick) begin
          next_r.tick_cnt = r.tick_cnt + 5'h01;
          if (r.tick_cnt == `ACSA_WARM_TICKS - 5'h01) begin
            next_r.tick_cnt = 5'h00;
            next_r.state = acsa_pkg::ACSA_LAUNCH;
          end
        end
      end
      acsa_pkg::ACSA_LAUNCH: begin
        next_r.conv.sample = 1'b1;
        next_r.conv.channel = r.ch;
        next_r.tick_cnt = 5'h00;
        next_r.state = acsa_pkg::ACSA_CONV;
      end
      acsa_pkg::ACSA_CONV: begin
        if (tick) begin
          next_r.tick_cnt = r.tick_cnt + 5'h01;
          if (r.tick_cnt == `ACSA_CONV_TICKS - 5'h01) begin
            next_r.conv.done = 1'b1;
            next_r.conv.seq_end = nx[4];
            next_r.conv.flag = !r.seq.mode || nx[4];
            next_r.ch = nx[4] ? first[3:0] : nx[3:0];
            if (!r.seq.en || r.seq.single) begin
              next_r.state = acsa_pkg::ACSA_IDLE;
            end else if (!nx[4] || r.seq.burst) begin
              next_r.state = acsa_pkg::ACSA_LAUNCH;
            end else begin
              next_r.state = acsa_pkg::ACSA_IDLE;
            end
          end
        end
      end
      default: begin
        next_r.state = acsa_pkg::ACSA_IDLE;
      end
    endcase
    // Register writes
    if (wr_i && addr_i == `ACSA_CTRL_ADDR) begin
      next_r.ctrl.converter_clock_divider = wdata_i[`ACSA_DIV_MSB:0];
      next_r.ctrl.async_sel = wdata_i[`ACSA_ASYNC_BIT];
      next_r.ctrl.lp = wdata_i[`ACSA_LP_BIT];
    end
    if (wr_i && addr_i == `ACSA_SEQ_ADDR) begin
      next_r.seq.mask = wdata_i[`ACSA_MASK_MSB:0];
      next_r.seq.trig_sel = wdata_i[`ACSA_TRIG_MSB:`ACSA_TRIG_LSB];
      next_r.seq.pol = wdata_i[`ACSA_POL_BIT];
      next_r.seq.skip = wdata_i[`ACSA_SKIP_BIT];
      next_r.seq.burst = wdata_i[`ACSA_BURST_BIT];
      next_r.seq.single = wdata_i[`ACSA_SINGLE_BIT];
      next_r.seq.mode = wdata_i[`ACSA_MODE_BIT];
      next_r.seq.en = wdata_i[`ACSA_EN_BIT];
    end
    // Register reads
    if (rd_i) begin
      case (addr_i)
        `ACSA_CTRL_ADDR: begin
          next_r.rdata = {21'h000000, r.ctrl.lp, 1'b0, r.ctrl.async_sel, r.ctrl.converter_clock_divider};
        end
        `ACSA_SEQ_ADDR: begin
          next_r.rdata = {r.seq.en, r.seq.mode, 1'b0, r.seq.single, r.seq.burst, 1'b0, 6'h00,
                          r.seq.skip, r.seq.pol, 3'h0, r.seq.trig_sel, r.seq.mask};
        end
        `ACSA_STAT_ADDR: begin
          next_r.rdata = {25'h0000000, analog_power_o, busy_o, 1'b0, r.ch};
        end
        default: begin
          next_r.rdata = 32'h00000000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r <= acsa_pkg::acsa_regs_type'(`ACSA_RESET_VALUE);
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign rdata_o = r.rdata;
  assign conv_o = r.conv;
  assign busy_o = (r.state != acsa_pkg::ACSA_IDLE);
  assign analog_power_o = !analog_off_i && (!r.ctrl.lp || busy_o);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [5:0] conv_ticks;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      conv_ticks <= 6'h00;
    end else if (ce_i) begin
      if (r.state == acsa_pkg::ACSA_LAUNCH) begin
        conv_ticks <= 6'h00;
      end else if (r.state == acsa_pkg::ACSA_CONV && tick) begin
        conv_ticks <= conv_ticks + 6'h01;
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  property p_start_reads_zero;
    (rd_i && addr_i == `ACSA_SEQ_ADDR) |=> !rdata_o[`ACSA_START_BIT];
  endproperty
  a_start_reads_zero: assert property (p_start_reads_zero) else $error("start bit read as one");

  property p_bypass_latency;
    (ce_i && r.state == acsa_pkg::ACSA_IDLE && trigger && !r.ctrl.lp && r.seq.mask != 12'h000
     && r.seq.skip) ##1 ce_i |=> conv_o.sample;
  endproperty
  a_bypass_latency: assert property (p_bypass_latency) else $error("bypass launch not at two clocks");

  property p_power;
    (analog_off_i |-> !analog_power_o) and ((!analog_off_i && !r.ctrl.lp) |-> analog_power_o);
  endproperty
  a_power: assert property (p_power) else $error("analog power level wrong");

  property p_conv_len;
    conv_o.done |-> conv_ticks == 6'd31;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion not 31 converter clocks");

  property p_channel_selected;
    conv_o.sample |-> r.seq.mask[conv_o.channel];
  endproperty
  a_channel_selected: assert property (p_channel_selected) else $error("unselected channel sampled");

  property p_flag_mode;
    (conv_o.done && !r.seq.mode |-> conv_o.flag) and (conv_o.flag |-> conv_o.done && (!r.seq.mode || conv_o.seq_end));
  endproperty
  a_flag_mode: assert property (p_flag_mode) else $error("flag timing wrong for mode");

  property p_single_stop;
    (ce_i && r.state == acsa_pkg::ACSA_CONV && next_r.conv.done && r.seq.single) |=> !busy_o;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single step did not stop");

  property p_disable_stop;
    (ce_i && next_r.conv.done && !r.seq.en) |=> !busy_o ##1 (!busy_o || r.seq.en);
  endproperty
  a_disable_stop: assert property (p_disable_stop) else $error("disabled sequence kept converting");

  property p_busy_ignores;
    (ce_i && busy_o && r.state == acsa_pkg::ACSA_CONV && !next_r.conv.done) |=> busy_o;
  endproperty
  a_busy_ignores: assert property (p_busy_ignores) else $error("conversion aborted");

  c_seq_end: cover property (conv_o.done && conv_o.seq_end);
  c_burst_restart: cover property (conv_o.seq_end && r.seq.burst ##[1:4] conv_o.sample);
  c_warm: cover property (r.state == acsa_pkg::ACSA_WARM ##[1:1000] conv_o.sample);
  c_single: cover property (conv_o.done && r.seq.single);
endmodule // acsa_control

// ==== acsa_far_end.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// Trigger sources and independent clock
// ----------------------------------------
module acsa_far_end (
  input wire logic clk_i,
  input wire logic [2:0] line_i,
  input wire logic fire_i,
  input wire logic level_i,
  output logic [7:0] trig_o,
  output logic tick_o
);
  logic [1:0] div_cnt;
  initial begin
    trig_o = 8'h00;
    tick_o = 1'b0;
    div_cnt = 2'h0;
  end
  // Tick at a quarter of the bus clock
  always @(posedge clk_i) begin
    div_cnt <= div_cnt + 2'h1;
    tick_o <= (div_cnt == 2'h3);
  end
  // Levels change on whole clock periods only
  always @(posedge clk_i) begin
    if (fire_i) begin
      trig_o[line_i] <= level_i;
    end
  end
endmodule // acsa_far_end

// ==== testbench.sv ====
`timescale 1ns/100ps
module testbench;
  localparam logic [31:0] CA = 32'h4001c000;
  localparam logic [31:0] SA = 32'h4001c008;
  logic clk_i, srst_i, wr_i, rd_i, fire, level, analog_off_i, async_tick_i, analog_power_o, busy_o;
  logic [31:0] addr_i, wdata_i, rdata_o;
  logic [2:0] line;
  logic ce;
  logic [7:0] trig_i;
  acsa_pkg::acsa_conv_type conv_o;
  int n_errors, comparisons, n;
  acsa_control dut_u (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .trig_i(trig_i), .async_tick_i(async_tick_i),
    .analog_off_i(analog_off_i), .conv_o(conv_o), .analog_power_o(analog_power_o), .busy_o(busy_o));
  acsa_far_end far_u (.clk_i(clk_i), .line_i(line), .fire_i(fire), .level_i(level), .trig_o(trig_i),
    .tick_o(async_tick_i));
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(what, exp, rdata_o);
  endtask
  task automatic trig(input logic [2:0] l, input logic v);
    @(posedge clk_i);
    line <= l;
    level <= v;
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
  endtask
  task automatic wait_ev(input logic sel, input int lim);
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while ((sel ? conv_o.done : conv_o.sample) !== 1'b1 && n < lim);
    if (n >= lim) begin
      n_errors++;
      $display("CHECK FAILED wait expected event seen none");
      complete_run();
    end
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  // ----------------------------------------
  // Clock and test sequence
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    srst_i = 1'b1;
    {wr_i, rd_i, fire, level, analog_off_i} = 5'h00;
    ce = 1'b1;
    {addr_i, wdata_i, line} = '0;
    n_errors = 0;
    comparisons = 0;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(CA, 32'h00000000, "ctrl_reset");
    rd(SA, 32'h00000000, "seq_reset");
    rd(32'h4001c004, 32'h00000000, "unmapped");
    chk("power_on", 1, analog_power_o);
    ce <= 1'b0;
    wr(CA, 32'h00000001);
    ce <= 1'b1;
    rd(CA, 32'h00000000, "ce_freeze");
    $display("test reset done");
    wr(SA, 32'h800c3005);
    rd(SA, 32'h800c3005, "seq_rw");
    trig(3'h3, 1'b1);
    wait_ev(1'b0, 40);
    chk("skip_latency", 2, n);
    chk("first_ch", 0, conv_o.channel);
    wait_ev(1'b1, 80);
    chk("conv_len", 31, n);
    chk("flag_each", 1, conv_o.flag);
    wait_ev(1'b0, 20);
    chk("next_ch", 2, conv_o.channel);
    trig(3'h3, 1'b0);
    trig(3'h3, 1'b1);
    wait_ev(1'b1, 80);
    chk("seq_end", 1, conv_o.seq_end);
    settle(40);
    chk("busy_retrig", 0, busy_o);
    $display("test skip done");
    wr(SA, 32'h00000000);
    wr(CA, 32'h00000001);
    trig(3'h5, 1'b0);
    wr(SA, 32'h80005001);
    trig(3'h5, 1'b1);
    settle(8);
    chk("rise_ignored", 0, busy_o);
    trig(3'h5, 1'b0);
    wait_ev(1'b0, 40);
    chk("sync_latency", 4, n);
    wait_ev(1'b1, 100);
    chk("div_len", 62, n);
    $display("test sync done");
    wr(SA, 32'h00000000);
    wr(CA, 32'h00000000);
    wr(SA, 32'hd0000005);
    for (int i = 0; i < 3; i++) begin
      wr(SA, 32'hd4000005);
      wait_ev(1'b0, 20);
      chk("step_ch", (i == 1) ? 2 : 0, conv_o.channel);
      wait_ev(1'b1, 40);
      chk("step_flag", (i == 1) ? 1 : 0, conv_o.flag);
      settle(3);
      chk("step_idle", 0, busy_o);
    end
    rd(SA, 32'hd0000005, "start_reads_0");
    $display("test step done");
    wr(SA, 32'h00000000);
    wr(SA, 32'h88000002);
    wait_ev(1'b0, 20);
    chk("burst_ch", 1, conv_o.channel);
    wait_ev(1'b1, 40);
    wait_ev(1'b0, 20);
    chk("burst_again", 1, conv_o.channel);
    wr(SA, 32'h80000002);
    wait_ev(1'b1, 40);
    settle(40);
    chk("burst_stop", 0, busy_o);
    $display("test burst done");
    wr(SA, 32'h00000000);
    wr(CA, 32'h00000400);
    trig(3'h3, 1'b0);
    chk("lp_idle_off", 0, analog_power_o);
    wr(SA, 32'h800c3001);
    trig(3'h3, 1'b1);
    wait_ev(1'b0, 60);
    chk("lp_latency", 17, n);
    chk("lp_on", 1, analog_power_o);
    wait_ev(1'b1, 40);
    settle(3);
    chk("lp_off_again", 0, analog_power_o);
    @(posedge clk_i);
    analog_off_i <= 1'b1;
    trig(3'h3, 1'b0);
    trig(3'h3, 1'b1);
    settle(20);
    chk("sys_off", 0, analog_power_o);
    settle(80);
    @(posedge clk_i);
    analog_off_i <= 1'b0;
    $display("test low power done");
    wr(SA, 32'h00000000);
    wr(CA, 32'h00000109);
    wr(SA, 32'h80000001);
    wr(SA, 32'h84000001);
    wait_ev(1'b0, 60);
    wait_ev(1'b1, 200);
    chk("async_span", 1, n >= 121 && n <= 127);
    $display("test async done");
    complete_run();
  end
endmodule // testbench
